// ---- hw/axis_monitor_pkg.sv ----
// Package: register map, flag positions and input bundles of the monitor.
package axis_monitor_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [5:0] IDX_RUN_STATUS = 6'h00;
  localparam logic [5:0] IDX_BAD_PARAM = 6'h01;
  localparam logic [5:0] IDX_WARNING = 6'h02;
  localparam logic [5:0] IDX_ALARM = 6'h04;
  localparam logic [5:0] IDX_SCAN_CTRL = 6'h08;
  localparam logic [5:0] IDX_SCAN_COUNT = 6'h09;

  // Reset values.
  localparam logic [15:0] RUN_STATUS_RST = 16'h0000;
  localparam logic [15:0] BAD_PARAM_RST = 16'h0000;
  localparam logic [31:0] WARNING_RST = 32'h0000_0000;
  localparam logic [31:0] ALARM_RST = 32'h0000_0000;
  localparam logic [15:0] SCAN_COUNT_RST = 16'h0000;

  // Fixed parameters are reported from this number upward.
  localparam logic [15:0] FIXED_PARAM_BASE = 16'd1000;

  // Run status bit positions.
  localparam int RUN_READY_BIT = 0;
  localparam int RUN_ACTIVE_BIT = 1;
  localparam int RUN_BUSY_BIT = 2;
  localparam int RUN_DRV_READY_BIT = 3;
  localparam int RUN_LATCH_BIT = 4;

  // Warning bit positions.
  localparam int WRN_DEV_BIT = 0;
  localparam int WRN_SET_PRM_BIT = 1;
  localparam int WRN_FIX_PRM_BIT = 2;
  localparam int WRN_DRV_BIT = 3;
  localparam int WRN_CMD_BIT = 4;
  localparam int WRN_POS_OT_BIT = 6;
  localparam int WRN_NEG_OT_BIT = 7;
  localparam int WRN_SON_INC_BIT = 8;
  localparam int WRN_COMM_BIT = 9;
  localparam int WRN_STOP_BIT = 10;

  // Alarm bit positions.
  localparam int ALM_DRV_BIT = 0;
  localparam int ALM_POS_OT_BIT = 1;
  localparam int ALM_NEG_OT_BIT = 2;
  localparam int ALM_POS_SOFT_BIT = 3;
  localparam int ALM_NEG_SOFT_BIT = 4;
  localparam int ALM_SERVO_OFF_BIT = 5;
  localparam int ALM_POS_TIME_BIT = 6;
  localparam int ALM_TRAVEL_BIT = 7;
  localparam int ALM_SPEED_BIT = 8;
  localparam int ALM_DEV_BIT = 9;
  localparam int ALM_FLT_TYPE_BIT = 10;
  localparam int ALM_FLT_TC_BIT = 11;
  localparam int ALM_ZERO_BIT = 13;

  // Scan control: bit 0 holds the snapshot.
  localparam int CTRL_HOLD_BIT = 0;

  // Flags from the servo drive; these arrive from pins.
  typedef struct packed {
    logic ready;
    logic warning;
    logic alarm;
    logic comm_err;
    logic stop_active;
    logic pos_ot;
    logic neg_ot;
    logic servo_on;
  } drive_flags_t;

  // Flags from axis motion logic on core_clk.
  typedef struct packed {
    logic motion_ready;
    logic running;
    logic busy;
    logic latch_req;
    logic dev_warn;
    logic dev_alarm;
    logic set_prm_err;
    logic fix_prm_err;
    logic cmd_set_err;
    logic servo_on_req;
    logic pos_soft;
    logic neg_soft;
    logic pos_time_over;
    logic travel_over;
    logic speed_over;
    logic filt_type_err;
    logic filt_tc_err;
    logic zero_unset;
    logic prm_fixed;
    logic [15:0] prm_index;
  } axis_flags_t;

endpackage

// ---- hw/axis_monitor_status_bank.sv ----
// Monitor register bank for one motion axis; read-only except the scan control word.
`timescale 1ns/1ps

// Operation
// - Run status bit 0 shows axis ready for operation.
// - Run status bit 1 shows running with servo drive powered on.
// - Run status bit 2 shows axis system busy.
// - Run status bit 3 mirrors the servo drive ready condition.
// - Run status bit 4 shows latch request received; bits 5-F reserved.
// - Bad parameter word: setting numbers from 0, fixed from 1000.
// - Warning bit 0 shows excessive following deviation.
// - Warning bit 1 shows a setting parameter out of range.
// - Warning bit 2 shows a fixed parameter out of range.
// - Warning bit 3 shows the servo drive reports a warning.
// - Warning bit 4 shows motion command setting error; bit 5 reserved.
// - Warning bits 6 and 7 show positive and negative overtravel.
// - Warning bit 8 shows requested servo power-on not completed.
// - Warning bit 9 shows servo drive communication error.
// - Warning bit A shows drive stop input active; bits B-1F reserved.
// - Alarm bit 0 shows the servo drive raised an alarm.
// - Alarm bits 1 and 2 show positive and negative overtravel.
// - Alarm bits 3 and 4 show positive and negative software limit passed.
// - Alarm bit 5 shows servo off.
// - Alarm bit 6 shows positioning time exceeded.
// - Alarm bits 7 and 8 show excessive travel and excessive speed.
// - Alarm bit 9 shows excessive following deviation.
module axis_monitor_status_bank
  import axis_monitor_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic scan_tick,
  input wire drive_flags_t drive_flags,
  input wire axis_flags_t axis_flags,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);

  typedef enum logic [1:0] {
    SCAN_RUN = 2'b01,
    SCAN_HOLD = 2'b10
  } scan_state_t;

  // Byte address of a register index.
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [5:0] idx);
    byte_addr = ADDR_W'({idx, 2'b00});
  endfunction

  // Setting parameters count from zero, fixed ones from the base.
  function automatic logic [15:0] param_number(input logic fixed,
                                               input logic [15:0] idx);
    param_number = fixed ? 16'(FIXED_PARAM_BASE + idx) : idx;
  endfunction

  drive_flags_t drive_s1_q;
  drive_flags_t drive_s2_q;
  scan_state_t scan_state_q;
  logic [15:0] run_status_q;
  logic [15:0] bad_param_q;
  logic [31:0] warning_q;
  logic [31:0] alarm_q;
  logic [15:0] scan_count_q;
  logic [15:0] run_status_d;
  logic [31:0] warning_d;
  logic [31:0] alarm_d;
  logic [31:0] rdata_d;
  logic refresh;

  // Drive flags come from pins, so they pass two flops first.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      drive_s1_q <= '0;
      drive_s2_q <= '0;
    end else begin
      drive_s1_q <= drive_flags;
      drive_s2_q <= drive_s1_q;
    end
  end

  // Hold state follows the scan control bit; a write of bit 0 set freezes
  // the snapshot so software can read all words from one scan.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scan_state_q <= SCAN_RUN;
    end else if (reg_wr && reg_addr == byte_addr(IDX_SCAN_CTRL)) begin
      scan_state_q <= reg_wdata[CTRL_HOLD_BIT] ? SCAN_HOLD : SCAN_RUN;
    end
  end

  assign refresh = scan_tick && scan_state_q == SCAN_RUN;

  // Run status image; bits above 4 stay zero.
  always_comb begin
    run_status_d = '0;
    run_status_d[RUN_READY_BIT] = axis_flags.motion_ready;
    run_status_d[RUN_ACTIVE_BIT] = axis_flags.running
                                   && drive_s2_q.servo_on;
    run_status_d[RUN_BUSY_BIT] = axis_flags.busy;
    run_status_d[RUN_DRV_READY_BIT] = drive_s2_q.ready;
    run_status_d[RUN_LATCH_BIT] = axis_flags.latch_req;
  end

  // Warning image; bit 5 and bits B-1F stay zero.
  always_comb begin
    warning_d = '0;
    warning_d[WRN_DEV_BIT] = axis_flags.dev_warn;
    warning_d[WRN_SET_PRM_BIT] = axis_flags.set_prm_err;
    warning_d[WRN_FIX_PRM_BIT] = axis_flags.fix_prm_err;
    warning_d[WRN_DRV_BIT] = drive_s2_q.warning;
    warning_d[WRN_CMD_BIT] = axis_flags.cmd_set_err;
    warning_d[WRN_POS_OT_BIT] = drive_s2_q.pos_ot;
    warning_d[WRN_NEG_OT_BIT] = drive_s2_q.neg_ot;
    warning_d[WRN_SON_INC_BIT] = axis_flags.servo_on_req
                                 && !drive_s2_q.servo_on;
    warning_d[WRN_COMM_BIT] = drive_s2_q.comm_err;
    warning_d[WRN_STOP_BIT] = drive_s2_q.stop_active;
  end

  // Alarm image; bits C, E, F and the upper half stay zero.
  always_comb begin
    alarm_d = '0;
    alarm_d[ALM_DRV_BIT] = drive_s2_q.alarm;
    alarm_d[ALM_POS_OT_BIT] = drive_s2_q.pos_ot;
    alarm_d[ALM_NEG_OT_BIT] = drive_s2_q.neg_ot;
    alarm_d[ALM_POS_SOFT_BIT] = axis_flags.pos_soft;
    alarm_d[ALM_NEG_SOFT_BIT] = axis_flags.neg_soft;
    alarm_d[ALM_SERVO_OFF_BIT] = !drive_s2_q.servo_on;
    alarm_d[ALM_POS_TIME_BIT] = axis_flags.pos_time_over;
    alarm_d[ALM_TRAVEL_BIT] = axis_flags.travel_over;
    alarm_d[ALM_SPEED_BIT] = axis_flags.speed_over;
    alarm_d[ALM_DEV_BIT] = axis_flags.dev_alarm;
    alarm_d[ALM_FLT_TYPE_BIT] = axis_flags.filt_type_err;
    alarm_d[ALM_FLT_TC_BIT] = axis_flags.filt_tc_err;
    alarm_d[ALM_ZERO_BIT] = axis_flags.zero_unset;
  end

  // Snapshot of all words, taken once per scan so a read never mixes two
  // scans. The cost is up to one scan of latency on every flag.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      run_status_q <= RUN_STATUS_RST;
      bad_param_q <= BAD_PARAM_RST;
      warning_q <= WARNING_RST;
      alarm_q <= ALARM_RST;
    end else if (refresh) begin
      run_status_q <= run_status_d;
      bad_param_q <= param_number(axis_flags.prm_fixed,
                                  axis_flags.prm_index);
      warning_q <= warning_d;
      alarm_q <= alarm_d;
    end
  end

  // Counts the scans taken, wrapping; software sees refresh progress.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scan_count_q <= SCAN_COUNT_RST;
    end else if (refresh) begin
      scan_count_q <= scan_count_q + 16'h0001;
    end
  end

  // Read mux; monitor words ignore writes and unmapped reads give zero.
  always_comb begin
    rdata_d = '0;
    if (reg_addr == byte_addr(IDX_RUN_STATUS)) begin
      rdata_d = {16'h0000, run_status_q};
    end else if (reg_addr == byte_addr(IDX_BAD_PARAM)) begin
      rdata_d = {16'h0000, bad_param_q};
    end else if (reg_addr == byte_addr(IDX_WARNING)) begin
      rdata_d = warning_q;
    end else if (reg_addr == byte_addr(IDX_ALARM)) begin
      rdata_d = alarm_q;
    end else if (reg_addr == byte_addr(IDX_SCAN_CTRL)) begin
      rdata_d = {31'h0000_0000, scan_state_q == SCAN_HOLD};
    end else if (reg_addr == byte_addr(IDX_SCAN_COUNT)) begin
      rdata_d = {16'h0000, scan_count_q};
    end
  end

  // Read data stand for the one cycle after the strobe, zero otherwise.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? rdata_d : 32'h0000_0000;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_run_ready_snap: assert property (
    refresh |=> run_status_q[RUN_READY_BIT] == $past(axis_flags.motion_ready))
    else $error("run ready bit does not follow snapshot");

  a_run_active_snap: assert property (
    refresh |=> run_status_q[RUN_ACTIVE_BIT] ==
      ($past(axis_flags.running) && $past(drive_s2_q.servo_on)))
    else $error("running bit wrong");

  a_busy_latch_snap: assert property (
    refresh |=> run_status_q[RUN_BUSY_BIT] == $past(axis_flags.busy)
      && run_status_q[RUN_LATCH_BIT] == $past(axis_flags.latch_req))
    else $error("busy or latch bit wrong");

  // The snapshot sees the pin as it stood two edges before the scan.
  a_drive_ready_path: assert property (
    refresh |=> run_status_q[RUN_DRV_READY_BIT] ==
      $past(drive_flags.ready, 3))
    else $error("drive ready not reported after sync");

  a_run_reserved_zero: assert property (
    run_status_q[15:5] == 11'h000)
    else $error("run status reserved bits set");

  a_param_number_map: assert property (
    refresh |=> bad_param_q == ($past(axis_flags.prm_fixed) ?
      16'($past(axis_flags.prm_index) + FIXED_PARAM_BASE) :
      $past(axis_flags.prm_index)))
    else $error("bad parameter number mapping wrong");

  a_son_incomplete: assert property (
    refresh |=> warning_q[WRN_SON_INC_BIT] ==
      ($past(axis_flags.servo_on_req) && !$past(drive_s2_q.servo_on)))
    else $error("servo on incomplete bit wrong");

  a_servo_off_alarm: assert property (
    refresh |=> alarm_q[ALM_SERVO_OFF_BIT] == !$past(drive_s2_q.servo_on))
    else $error("servo off alarm wrong");

  a_warn_reserved_zero: assert property (
    warning_q[31:11] == 21'h00_0000 && !warning_q[5])
    else $error("warning reserved bits set");

  a_alarm_reserved_zero: assert property (
    alarm_q[31:14] == 18'h0_0000 && !alarm_q[12])
    else $error("alarm reserved bits set");

  a_hold_freezes: assert property (
    (scan_state_q == SCAN_HOLD) [*2] |-> $stable(warning_q)
      && $stable(alarm_q) && $stable(run_status_q))
    else $error("snapshot changed while held");

  a_read_one_cycle: assert property (
    !reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data outside the answer cycle");

  // Warning word: each bit follows its own source at the scan edge.
  a_dev_warn_snap: assert property (
    refresh |=> warning_q[WRN_DEV_BIT] == $past(axis_flags.dev_warn))
    else $error("deviation warning bit wrong");

  a_prm_err_snap: assert property (
    refresh |=> warning_q[WRN_SET_PRM_BIT] == $past(axis_flags.set_prm_err)
      && warning_q[WRN_FIX_PRM_BIT] == $past(axis_flags.fix_prm_err))
    else $error("parameter error bits wrong");

  a_drv_warn_snap: assert property (
    refresh |=> warning_q[WRN_DRV_BIT] == $past(drive_s2_q.warning))
    else $error("drive warning bit wrong");

  a_cmd_err_snap: assert property (
    refresh |=> warning_q[WRN_CMD_BIT] == $past(axis_flags.cmd_set_err))
    else $error("command setting error bit wrong");

  a_warn_ot_snap: assert property (
    refresh |=> warning_q[WRN_POS_OT_BIT] == $past(drive_s2_q.pos_ot)
      && warning_q[WRN_NEG_OT_BIT] == $past(drive_s2_q.neg_ot))
    else $error("overtravel warning bits wrong");

  a_comm_err_snap: assert property (
    refresh |=> warning_q[WRN_COMM_BIT] == $past(drive_s2_q.comm_err))
    else $error("communication warning bit wrong");

  a_stop_input_snap: assert property (
    refresh |=> warning_q[WRN_STOP_BIT] == $past(drive_s2_q.stop_active))
    else $error("stop input warning bit wrong");

  // Alarm word: overtravel shares the drive pins with the warning word.
  a_drv_alarm_snap: assert property (
    refresh |=> alarm_q[ALM_DRV_BIT] == $past(drive_s2_q.alarm))
    else $error("drive alarm bit wrong");

  a_alarm_ot_snap: assert property (
    refresh |=> alarm_q[ALM_POS_OT_BIT] == $past(drive_s2_q.pos_ot)
      && alarm_q[ALM_NEG_OT_BIT] == $past(drive_s2_q.neg_ot))
    else $error("overtravel alarm bits wrong");

  a_soft_limit_snap: assert property (
    refresh |=> alarm_q[ALM_POS_SOFT_BIT] == $past(axis_flags.pos_soft)
      && alarm_q[ALM_NEG_SOFT_BIT] == $past(axis_flags.neg_soft))
    else $error("software limit alarm bits wrong");

  a_pos_time_snap: assert property (
    refresh |=> alarm_q[ALM_POS_TIME_BIT] ==
      $past(axis_flags.pos_time_over))
    else $error("positioning time alarm bit wrong");

  a_travel_speed_snap: assert property (
    refresh |=> alarm_q[ALM_TRAVEL_BIT] == $past(axis_flags.travel_over)
      && alarm_q[ALM_SPEED_BIT] == $past(axis_flags.speed_over))
    else $error("travel or speed alarm bit wrong");

  a_dev_alarm_snap: assert property (
    refresh |=> alarm_q[ALM_DEV_BIT] == $past(axis_flags.dev_alarm))
    else $error("deviation alarm bit wrong");

  a_filter_zero_snap: assert property (
    refresh |=> alarm_q[ALM_FLT_TYPE_BIT] == $past(axis_flags.filt_type_err)
      && alarm_q[ALM_FLT_TC_BIT] == $past(axis_flags.filt_tc_err)
      && alarm_q[ALM_ZERO_BIT] == $past(axis_flags.zero_unset))
    else $error("filter or zero point alarm bit wrong");

  // A held scan must not advance the count, or software loses track.
  a_count_hold: assert property (
    scan_state_q == SCAN_HOLD |=> $stable(scan_count_q))
    else $error("scan count moved while held");

  a_count_step: assert property (
    refresh |=> scan_count_q == 16'($past(scan_count_q) + 16'h0001))
    else $error("scan count did not step");

  a_read_alarm_word: assert property (
    reg_rd && reg_addr == byte_addr(IDX_ALARM)
      |=> reg_rdata == $past(alarm_q))
    else $error("alarm read data wrong");

  c_refresh_taken: cover property (refresh ##1 alarm_q != 32'h0000_0000);
  c_fixed_param: cover property (refresh && axis_flags.prm_fixed);
  c_hold_then_read: cover property (scan_state_q == SCAN_HOLD && reg_rd);
  c_held_scan: cover property (scan_state_q == SCAN_HOLD && scan_tick);
  c_servo_off_read: cover property (alarm_q[ALM_SERVO_OFF_BIT] && reg_rd);

endmodule

// ---- verification/axis_far_side.sv ----
// Behavioural far side: servo drive pins and axis motion logic flags.
`timescale 1ns/1ps
module axis_far_side
  import axis_monitor_pkg::*;
(
  input wire logic core_clk,
  input wire drive_flags_t drive_cmd,
  input wire axis_flags_t axis_cmd,
  output drive_flags_t drive_flags,
  output axis_flags_t axis_flags
);
  // Levels change just after an edge, as real drive outputs would settle.
  always_ff @(posedge core_clk) begin
    drive_flags <= drive_cmd;
    axis_flags <= axis_cmd;
  end
endmodule

// ---- verification/tb_top.sv ----
// Self-checking bench for the axis monitor register bank.
`timescale 1ns/1ps
module tb_top;
  import axis_monitor_pkg::*;
  logic core_clk;
  logic rst;
  logic scan_tick;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  drive_flags_t drive_cmd;
  drive_flags_t drive_flags;
  axis_flags_t axis_cmd;
  axis_flags_t axis_flags;
  int errors;
  int comparisons;

  axis_far_side far (
    .core_clk(core_clk),
    .drive_cmd(drive_cmd),
    .axis_cmd(axis_cmd),
    .drive_flags(drive_flags),
    .axis_flags(axis_flags)
  );

  axis_monitor_status_bank #(.ADDR_W(8)) dut (
    .core_clk(core_clk),
    .rst(rst),
    .scan_tick(scan_tick),
    .drive_flags(drive_flags),
    .axis_flags(axis_flags),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata)
  );

  // Free-running 100 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // One place compares; an unknown never passes for a match.
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Single-cycle write strobe.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input string name);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    check(name, reg_rdata, exp);
  endtask

  task automatic rd_all(input logic [31:0] run, input logic [31:0] bad,
                        input logic [31:0] wrn, input logic [31:0] alm);
    rd(8'h00, run, "run_status");
    rd(8'h04, bad, "bad_param");
    rd(8'h08, wrn, "warning");
    rd(8'h10, alm, "alarm");
  endtask

  // Let the drive pins clear the two synchroniser flops, then scan once.
  task automatic scan();
    repeat (3) @(posedge core_clk);
    scan_tick <= 1'b1;
    @(posedge core_clk);
    scan_tick <= 1'b0;
  endtask

  // Pattern 0 clears with servo off, 1 sets every source, 2 mixes them
  // so that warning bits 0-7 alternate and a swapped source would show.
  task automatic pattern(input int unsigned p);
    drive_flags_t d;
    axis_flags_t x;
    d = '0;
    x = '0;
    if (p == 1) begin
      d = '1;
      x = '1;
    end
    x.running = 1'b1;
    x.servo_on_req = (p != 2);
    x.prm_index = (p == 1) ? 16'h0005 : 16'h0007;
    if (p == 2) begin
      d.ready = 1'b1;
      d.alarm = 1'b1;
      d.stop_active = 1'b1;
      d.pos_ot = 1'b1;
      d.servo_on = 1'b1;
      x.busy = 1'b1;
      x.dev_warn = 1'b1;
      x.fix_prm_err = 1'b1;
      x.cmd_set_err = 1'b1;
      x.pos_soft = 1'b1;
      x.travel_over = 1'b1;
      x.dev_alarm = 1'b1;
      x.filt_tc_err = 1'b1;
      x.prm_index = 16'h0123;
    end
    // One assignment each, so no signal is written twice in a time step.
    drive_cmd <= d;
    axis_cmd <= x;
  endtask

  // A hang is cut short and counted.
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    report_and_stop();
  end

  // Main sequence.
  initial begin
    rst = 1'b1;
    scan_tick = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    drive_cmd = '0;
    axis_cmd = '0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    rd_all(32'h0, 32'h0, 32'h0, 32'h0);
    pattern(1'b1);
    scan();
    // Fixed parameter 5 reads as 1005; running only counts with servo on.
    rd_all(32'h0000_001F, 32'h0000_03ED, 32'h0000_06DF, 32'h0000_2FDF);
    pattern(1'b0);
    scan();
    // Servo off: incomplete power-on warning and servo-off alarm only.
    rd_all(32'h0, 32'h0000_0007, 32'h0000_0100, 32'h0000_0020);
    // Without a scan the words keep their last snapshot.
    pattern(1'b1);
    repeat (4) @(posedge core_clk);
    rd(8'h08, 32'h0000_0100, "no_scan");
    wr(8'h08, 32'hFFFF_FFFF);
    wr(8'h00, 32'hFFFF_FFFF);
    rd(8'h08, 32'h0000_0100, "ro_warning");
    rd(8'h00, 32'h0, "ro_run");
    rd(8'h0C, 32'h0, "unmapped");
    rd(8'h01, 32'h0, "misaligned");
    // Hold freezes the snapshot; release lets the next scan through.
    wr(8'h20, 32'h0000_0001);
    rd(8'h20, 32'h0000_0001, "hold");
    scan();
    rd(8'h10, 32'h0000_0020, "held_alarm");
    wr(8'h20, 32'h0000_0000);
    scan();
    rd_all(32'h0000_001F, 32'h0000_03ED, 32'h0000_06DF, 32'h0000_2FDF);
    // Mixed sources; setting parameter 0x123 reads as it is.
    pattern(2);
    scan();
    rd_all(32'h0000_000E, 32'h0000_0123, 32'h0000_0455, 32'h0000_0A8B);
    // Four scans were taken; the held one did not count.
    rd(8'h24, 32'h0000_0004, "scan_count");
    // A reset in mid-run clears every word and releases a hold.
    wr(8'h20, 32'h0000_0001);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rd_all(32'h0, 32'h0, 32'h0, 32'h0);
    rd(8'h20, 32'h0, "hold_after_rst");
    rd(8'h24, 32'h0, "count_after_rst");
    report_and_stop();
  end
endmodule
